// File: verilog/copy_mgmt_map.vh
// register offsets, field positions, line numbers and codes of the inserter
`ifndef COPY_MGMT_MAP_VH
`define COPY_MGMT_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_EDHD_COPY_CONTROL 8'h32
`define OFS_COPY_DATA_0 8'h41
`define OFS_COPY_DATA_1 8'h42
`define OFS_COPY_DATA_2 8'h43
`define OFS_TYPEB_FIRST 8'h5e
`define OFS_TYPEB_LAST 8'h6e
`define OFS_SD_COPY_CONTROL_DATA 8'h99
`define OFS_SD_COPY_DATA_1 8'h9a
`define OFS_SD_COPY_DATA_2 8'h9b

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_REG 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_EDHD_ENABLE 6
`define BIT_EDHD_CRC 7
`define BIT_TYPEB_ENABLE 0
`define BIT_TYPEB_CRC 1
`define BIT_SD_CRC 4
`define BIT_SD_ODD 5
`define BIT_SD_EVEN 6
`define TYPEB_HDR_HI 7
`define TYPEB_HDR_LO 2

// ----------------------------------------------------------------------
// packet sizes and check sequence
// ----------------------------------------------------------------------
`define PLAIN_BITS 8'h14
`define PLAIN_PAYLOAD_BITS 8'h0e
`define TYPEB_BITS 8'h86
`define TYPEB_PAYLOAD_BITS 8'h80
`define CRC_PRESET 6'h3f

// ----------------------------------------------------------------------
// video format codes
// ----------------------------------------------------------------------
`define FMT_SD 3'h0
`define FMT_525P 3'h1
`define FMT_625P 3'h2
`define FMT_720P 3'h3
`define FMT_1080I 3'h4

// ----------------------------------------------------------------------
// insertion lines
// ----------------------------------------------------------------------
`define LINE_SD_ODD 11'h014
`define LINE_SD_EVEN 11'h11b
`define LINE_525P_PLAIN 11'h029
`define LINE_525P_TYPEB 11'h028
`define LINE_625P_PLAIN 11'h02b
`define LINE_720P_PLAIN 11'h018
`define LINE_720P_TYPEB 11'h017
`define LINE_1080I_PLAIN_A 11'h013
`define LINE_1080I_PLAIN_B 11'h246
`define LINE_1080I_TYPEB_A 11'h012
`define LINE_1080I_TYPEB_B 11'h245

`endif

// File: verilog/copy_bit_serializer.v
// serializer that sends a latched packet lowest bit first
`timescale 1ns/100ps
module copy_bit_serializer
(
  input wire clk_sys,
  input wire sys_rst,
  input wire clkEn,
  input wire load,
  input wire [133:0] packetIn,
  input wire [7:0] lengthIn,
  input wire withRef,
  input wire bitTick,
  output reg bitValid,
  output reg bitData,
  output reg refPulse,
  output wire busy
);

  // --------------------------------------------------------------------
  // shift state
  // --------------------------------------------------------------------
  reg [133:0] shiftReg;
  reg [7:0] bitsLeft;
  reg refPending;

  assign busy = (bitsLeft != 8'h00) || refPending;

  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shiftReg <= 134'h0;
      bitsLeft <= 8'h00;
      refPending <= 1'b0;
      bitValid <= 1'b0;
      bitData <= 1'b0;
      refPulse <= 1'b0;
    end
    else if (clkEn)
    begin
      if (load)
      begin
        shiftReg <= packetIn;
        bitsLeft <= lengthIn;
        refPending <= withRef;
        bitValid <= 1'b0;
        bitData <= 1'b0;
        refPulse <= 1'b0;
      end
      else if (bitTick)
      begin
        if (refPending)
        begin
          // reference pulse: same level and length as one data bit
          refPending <= 1'b0;
          bitValid <= 1'b1;
          bitData <= 1'b1;
          refPulse <= 1'b1;
        end
        else if (bitsLeft != 8'h00)
        begin
          bitValid <= 1'b1;
          bitData <= shiftReg[0];
          refPulse <= 1'b0;
          shiftReg <= {1'b0, shiftReg[133:1]};
          bitsLeft <= bitsLeft - 8'h01;
        end
        else
        begin
          bitValid <= 1'b0;
          bitData <= 1'b0;
          refPulse <= 1'b0;
        end
      end
    end
  end

endmodule // copy_bit_serializer

// File: verilog/vbi_copy_mgmt_inserter.v
// copy management packet inserter for the vertical blanking interval
// Functional notes
// - SD packet goes on line 20 of odd fields and line 283 of even.
// - SD control bits 6:5 choose odd fields, even fields or both.
// - SD packet is sent only in NTSC operation, suppressed otherwise.
// - The plain packet is exactly 20 data bits.
// - A reference pulse one bit long and high precedes the SD packet.
// - ED/HD enable in 525p inserts the 20-bit packet on line 41.
// - Type B enable in 525p inserts the Type B packet on line 40.
// - ED/HD enable in 625p uses line 43, data from data 1 and 2.
// - ED/HD enable in 720p places the 20-bit packet on line 24.
// - ED/HD enable in 1080i places the packet on lines 19 and 582.
// - Type B enable in 720p places the Type B packet on line 23.
// - Type B enable in 1080i uses lines 18 and 581.
// - 525p and HD plain packets come from copy data 0 to 2.
// - Type B packets come from the register range 0x5E to 0x6E.
// - CRC enable replaces top six plain bits with CRC of low fourteen.
// - Check uses polynomial x^6+x+1, preset all ones.
// - CRC disabled: all twenty bits come straight from registers, but 625p sends the top four as zero.
// - Type B CRC enable: top six bits from 128 lower, 134 bits out.
// - Type B CRC disabled: all 134 bits come from registers.
`timescale 1ns/100ps
`include "copy_mgmt_map.vh"
module vbi_copy_mgmt_inserter
(
  input wire clk_sys,
  input wire sys_rst,
  input wire clkEn,
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  input wire [2:0] videoFormat,
  input wire sdNtsc,
  input wire lineStart,
  input wire [10:0] lineNum,
  input wire evenField,
  input wire bitTick,
  output wire packetBitValid,
  output wire packetBit,
  output wire refPulse,
  output wire insertBusy
);

  // --------------------------------------------------------------------
  // check sequence helpers
  // --------------------------------------------------------------------
  // one step of x^6 + x + 1, fed with the bit that goes out next
  function [5:0] crcStep;
    input [5:0] crc;
    input din;
    reg fb;
    begin
      fb = crc[5] ^ din;
      crcStep = {crc[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
  endfunction

  // check value over the first n bits of d, lowest bit first
  function [5:0] crcOf;
    input [127:0] d;
    input [7:0] n;
    integer i;
    reg [5:0] c;
    begin
      c = `CRC_PRESET;
      for (i = 0; i < 128; i = i + 1)
      begin
        if (i < n)
          c = crcStep(c, d[i]);
      end
      crcOf = c;
    end
  endfunction

  // first check bit sent is the top bit of the shift register
  function [5:0] crcOrder;
    input [5:0] c;
    begin
      crcOrder = {c[0], c[1], c[2], c[3], c[4], c[5]};
    end
  endfunction

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg [7:0] edhdCopyControl;
  reg [7:0] copyData0;
  reg [7:0] copyData1;
  reg [7:0] copyData2;
  reg [7:0] typeb [0:16];
  reg [7:0] sdCopyControlData;
  reg [7:0] sdCopyData1;
  reg [7:0] sdCopyData2;
  reg [7:0] rdMux;
  wire typebHit;
  wire [4:0] typebIdx;
  integer k;
  integer m;

  assign typebHit = (regAddr >= `OFS_TYPEB_FIRST) &&
                    (regAddr <= `OFS_TYPEB_LAST);
  assign typebIdx = regAddr[4:0] - 5'h1e;

  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      edhdCopyControl <= `RST_REG;
      copyData0 <= `RST_REG;
      copyData1 <= `RST_REG;
      copyData2 <= `RST_REG;
      sdCopyControlData <= `RST_REG;
      sdCopyData1 <= `RST_REG;
      sdCopyData2 <= `RST_REG;
      for (k = 0; k < 17; k = k + 1)
        typeb[k] <= `RST_REG;
    end
    else if (clkEn && regWrEn)
    begin
      case (regAddr)
        `OFS_EDHD_COPY_CONTROL: edhdCopyControl <= regWrData;
        `OFS_COPY_DATA_0: copyData0 <= regWrData;
        `OFS_COPY_DATA_1: copyData1 <= regWrData;
        `OFS_COPY_DATA_2: copyData2 <= regWrData;
        `OFS_SD_COPY_CONTROL_DATA: sdCopyControlData <= regWrData;
        `OFS_SD_COPY_DATA_1: sdCopyData1 <= regWrData;
        `OFS_SD_COPY_DATA_2: sdCopyData2 <= regWrData;
        default:
        begin
          if (typebHit)
            typeb[typebIdx] <= regWrData;
        end
      endcase
    end
  end

  always @*
  begin
    case (regAddr)
      `OFS_EDHD_COPY_CONTROL: rdMux = edhdCopyControl;
      `OFS_COPY_DATA_0: rdMux = copyData0;
      `OFS_COPY_DATA_1: rdMux = copyData1;
      `OFS_COPY_DATA_2: rdMux = copyData2;
      `OFS_SD_COPY_CONTROL_DATA: rdMux = sdCopyControlData;
      `OFS_SD_COPY_DATA_1: rdMux = sdCopyData1;
      `OFS_SD_COPY_DATA_2: rdMux = sdCopyData2;
      default: rdMux = typebHit ? typeb[typebIdx] : 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      regRdData <= 8'h00;
    else if (clkEn)
      regRdData <= rdMux;
  end

  // --------------------------------------------------------------------
  // line decode
  // --------------------------------------------------------------------
  wire edhdEnable;
  wire edhdCrc;
  wire typebEnable;
  wire typebCrc;
  wire sdCrc;
  reg plainLine;
  reg typebLine;
  reg sdLine;

  assign edhdEnable = edhdCopyControl[`BIT_EDHD_ENABLE];
  assign edhdCrc = edhdCopyControl[`BIT_EDHD_CRC];
  assign typebEnable = typeb[0][`BIT_TYPEB_ENABLE];
  assign typebCrc = typeb[0][`BIT_TYPEB_CRC];
  assign sdCrc = sdCopyControlData[`BIT_SD_CRC];

  always @*
  begin
    plainLine = 1'b0;
    typebLine = 1'b0;
    sdLine = 1'b0;
    case (videoFormat)
      `FMT_SD:
      begin
        sdLine = sdNtsc &&
          ((!evenField && sdCopyControlData[`BIT_SD_ODD] &&
            lineNum == `LINE_SD_ODD) ||
           (evenField && sdCopyControlData[`BIT_SD_EVEN] &&
            lineNum == `LINE_SD_EVEN));
      end
      `FMT_525P:
      begin
        plainLine = edhdEnable && lineNum == `LINE_525P_PLAIN;
        typebLine = typebEnable && lineNum == `LINE_525P_TYPEB;
      end
      `FMT_625P:
        plainLine = edhdEnable && lineNum == `LINE_625P_PLAIN;
      `FMT_720P:
      begin
        plainLine = edhdEnable && lineNum == `LINE_720P_PLAIN;
        typebLine = typebEnable && lineNum == `LINE_720P_TYPEB;
      end
      `FMT_1080I:
      begin
        plainLine = edhdEnable &&
          (lineNum == `LINE_1080I_PLAIN_A ||
           lineNum == `LINE_1080I_PLAIN_B);
        typebLine = typebEnable &&
          (lineNum == `LINE_1080I_TYPEB_A ||
           lineNum == `LINE_1080I_TYPEB_B);
      end
      default:
      begin
        plainLine = 1'b0;
        typebLine = 1'b0;
        sdLine = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // packet assembly
  // --------------------------------------------------------------------
  wire [19:0] edhdRaw;
  wire [19:0] sdRaw;
  wire [19:0] plainRaw;
  wire plainCrcOn;
  wire [19:0] plainPacket;
  wire [133:0] typebRaw;
  wire [133:0] typebPacket;
  reg [127:0] typebPayload;
  reg [133:0] next_packet;
  reg [7:0] next_length;
  reg next_withRef;
  wire loadPacket;

  // 625p ignores copy data 0
  assign edhdRaw = {(videoFormat == `FMT_625P) ? 4'h0 : copyData0[3:0],
                    copyData1, copyData2};
  assign sdRaw = {sdCopyControlData[3:0], sdCopyData1, sdCopyData2};
  assign plainRaw = (videoFormat == `FMT_SD) ? sdRaw : edhdRaw;
  assign plainCrcOn = (videoFormat == `FMT_SD) ? sdCrc : edhdCrc;

  // plain packet: 20 bits, check bits on top when enabled
  assign plainPacket = plainCrcOn ?
    {crcOrder(crcOf({114'h0, plainRaw[13:0]}, `PLAIN_PAYLOAD_BITS)),
     plainRaw[13:0]} :
    plainRaw;

  always @*
  begin
    typebPayload = 128'h0;
    for (m = 1; m < 17; m = m + 1)
      typebPayload[(m - 1) * 8 +: 8] = typeb[m];
  end

  // header bits from the control register sit under the payload
  assign typebRaw = {typebPayload,
    typeb[0][`TYPEB_HDR_HI:`TYPEB_HDR_LO]};
  assign typebPacket = typebCrc ?
    {crcOrder(crcOf(typebRaw[127:0], `TYPEB_PAYLOAD_BITS)),
     typebRaw[127:0]} :
    typebRaw;

  always @*
  begin
    next_packet = 134'h0;
    next_length = 8'h00;
    next_withRef = 1'b0;
    if (typebLine)
    begin
      next_packet = typebPacket;
      next_length = `TYPEB_BITS;
    end
    else if (plainLine || sdLine)
    begin
      next_packet = {114'h0, plainPacket};
      next_length = `PLAIN_BITS;
      next_withRef = sdLine;
    end
  end

  // contents are latched once, at the start of the line
  assign loadPacket = lineStart && (plainLine || typebLine || sdLine);

  // --------------------------------------------------------------------
  // serializer
  // --------------------------------------------------------------------
  copy_bit_serializer u_serializer
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .load(loadPacket),
    .packetIn(next_packet),
    .lengthIn(next_length),
    .withRef(next_withRef),
    .bitTick(bitTick),
    .bitValid(packetBitValid),
    .bitData(packetBit),
    .refPulse(refPulse),
    .busy(insertBusy)
  );

endmodule // vbi_copy_mgmt_inserter

// File: dv/vbi_copy_mgmt_inserter_assertions.sv
// port checker of the copy management inserter
`timescale 1ns/100ps
`include "copy_mgmt_map.vh"
module vbi_copy_mgmt_checker
(
  input wire clk_sys,
  input wire sys_rst,
  input wire clkEn,
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire [2:0] videoFormat,
  input wire sdNtsc,
  input wire lineStart,
  input wire [10:0] lineNum,
  input wire evenField,
  input wire bitTick,
  input wire packetBitValid,
  input wire packetBit,
  input wire refPulse,
  input wire insertBusy
);
  reg [10:0] lastLine;
  reg lastEven;
  reg [7:0] bitCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // line of the last line start and bits sent since
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      lastLine <= 11'h000;
      lastEven <= 1'b0;
      bitCnt <= 8'h00;
    end
    else if (lineStart)
    begin
      lastLine <= lineNum;
      lastEven <= evenField;
      bitCnt <= 8'h00;
    end
    else if ($past(bitTick) && packetBitValid)
      bitCnt <= bitCnt + 8'h01;
  a_ref_high: assert property (refPulse |-> packetBit && packetBitValid)
    else $error("reference pulse is not a high bit");
  a_ref_leads: assert property ($rose(refPulse) |-> $rose(packetBitValid))
    else $error("reference pulse is not first");
  a_ref_ntsc: assert property (refPulse |-> videoFormat == `FMT_SD && sdNtsc)
    else $error("reference pulse outside ntsc");
  a_ref_line: assert property ($rose(refPulse) |-> (lastEven ?
    lastLine == `LINE_SD_EVEN : lastLine == `LINE_SD_ODD))
    else $error("sd packet on wrong line");
  a_bit_hold: assert property (!bitTick && !lineStart |=>
    $stable(packetBit) && $stable(packetBitValid))
    else $error("bit changed without tick");
  a_start_tick: assert property ($rose(packetBitValid) |-> $past(bitTick))
    else $error("packet started without tick");
  a_len_legal: assert property ($fell(packetBitValid) |->
    bitCnt inside {8'h14, 8'h15, `TYPEB_BITS})
    else $error("packet length wrong");
  a_len_plain: assert property ($fell(packetBitValid) && bitCnt == 8'h14 |->
    lastLine inside {11'h029, 11'h02b, 11'h018, 11'h013, 11'h246})
    else $error("plain packet on wrong line");
  a_len_typeb: assert property ($fell(packetBitValid) && bitCnt == 8'h86 |->
    lastLine inside {11'h028, 11'h017, 11'h012, 11'h245})
    else $error("type b packet on wrong line");
endmodule // vbi_copy_mgmt_checker

bind vbi_copy_mgmt_inserter vbi_copy_mgmt_checker chk_u (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .clkEn(clkEn), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .videoFormat(videoFormat),
  .sdNtsc(sdNtsc), .lineStart(lineStart), .lineNum(lineNum),
  .evenField(evenField), .bitTick(bitTick), .packetBitValid(packetBitValid),
  .packetBit(packetBit), .refPulse(refPulse), .insertBusy(insertBusy));

// File: dv/video_timing_model.sv
// timing and output path model: bit ticks and packet capture
`timescale 1ns/100ps
module video_timing_model
(
  input wire clk_sys,
  input wire sys_rst,
  input wire lineStart,
  input wire packetBitValid,
  input wire packetBit,
  input wire refPulse,
  output wire bitTick,
  output reg [135:0] capBits,
  output reg [7:0] capCnt,
  output reg refSeen
);
  reg [1:0] phase;
  reg tickSeen;
  // one tick every four cycles, phase restarts at each line
  assign bitTick = phase == 2'h3;
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      phase <= 2'h0;
      tickSeen <= 1'b0;
      capBits <= 136'h0;
      capCnt <= 8'h00;
      refSeen <= 1'b0;
    end
    else
    begin
      phase <= lineStart ? 2'h0 : phase + 2'h1;
      tickSeen <= bitTick;
      if (lineStart)
      begin
        capBits <= 136'h0;
        capCnt <= 8'h00;
        refSeen <= 1'b0;
      end
      else if (tickSeen && packetBitValid)
      begin
        capBits[capCnt] <= packetBit;
        capCnt <= capCnt + 8'h01;
        refSeen <= refSeen | refPulse;
      end
    end
endmodule // video_timing_model

// File: dv/tb.sv
// self-checking bench of the copy management inserter
`timescale 1ns/100ps
`include "copy_mgmt_map.vh"
module tb;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg clkEn = 1'b1;
  reg regWrEn = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] regWrData = 8'h00;
  reg [2:0] videoFormat = 3'h0;
  reg sdNtsc = 1'b0;
  reg lineStart = 1'b0;
  reg evenField = 1'b0;
  reg [10:0] lineNum = 11'h000;
  wire [7:0] regRdData;
  wire bitTick, packetBitValid, packetBit, refPulse, insertBusy, refSeen;
  wire [135:0] capBits;
  wire [7:0] capCnt;
  integer error_cnt = 0;
  integer checks_done = 0;
  integer cycles = 0;
  integer i;
  reg [133:0] typeB;
  reg [18:0] rows [0:13];
  reg [143:0] ev;
  localparam [79:0] ADRS = 80'h3241_425e_6e99_9a9b_4443;
  vbi_copy_mgmt_inserter dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clkEn(clkEn), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .videoFormat(videoFormat),
    .sdNtsc(sdNtsc), .lineStart(lineStart), .lineNum(lineNum),
    .evenField(evenField), .bitTick(bitTick), .packetBitValid(packetBitValid),
    .packetBit(packetBit), .refPulse(refPulse), .insertBusy(insertBusy));
  video_timing_model timing_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .lineStart(lineStart), .packetBitValid(packetBitValid),
    .packetBit(packetBit), .refPulse(refPulse), .bitTick(bitTick),
    .capBits(capBits), .capCnt(capCnt), .refSeen(refSeen));
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task check(input [143:0] seen, input [143:0] want);
  begin
    checks_done = checks_done + 1;
    if (seen !== want)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk_sys);
    #1;
  end
  endtask
  task rd(input [7:0] a);
  begin
    regWrEn = 1'b0;
    regAddr = a;
    @(posedge clk_sys);
    #1;
  end
  endtask
  task startLine(input [18:0] r);
  begin
    regWrEn = 1'b0;
    {videoFormat, sdNtsc, evenField, lineNum} = r[18:3];
    lineStart = 1'b1;
    @(posedge clk_sys);
    #1;
    lineStart = 1'b0;
  end
  endtask
  task waitDone;
    integer k;
  begin
    regWrEn = 1'b0;
    for (k = 0; k < 700 && (k < 8 || packetBitValid || insertBusy); k++)
    begin
      @(posedge clk_sys);
      #1;
    end
  end
  endtask
  task runLine(input [18:0] r);
  begin
    startLine(r);
    waitDone;
  end
  endtask
  function [5:0] crc6(input [127:0] d, input [7:0] n);
    reg [5:0] c;
    reg fb;
    integer j;
  begin
    c = `CRC_PRESET;
    for (j = 0; j < n; j++)
    begin
      fb = c[5] ^ d[j];
      c = {c[4:0], fb} ^ {4'h0, fb, 1'h0};
    end
    for (j = 0; j < 6; j++)
      crc6[j] = c[5 - j];
  end
  endfunction
  function [143:0] expOf(input [2:0] kind);
  begin
    expOf = 144'h0;
    case (kind)
      3'h1: expOf[143:0] = {8'h15, 115'h0, 20'hb1234, 1'h1};
      3'h2: expOf[143:0] = {8'h14, 116'h0, 20'ha5c3e};
      3'h3: expOf[143:0] = {8'h14, 116'h0, 20'h05c3e};
      3'h4: expOf[143:0] = {8'h86, 2'h0, typeB};
      default: expOf = 144'h0;
    endcase
  end
  endfunction
  task conclude;
  begin
    $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    rows[0] = {`FMT_SD, 2'h2, `LINE_SD_ODD, 3'h1};
    rows[1] = {`FMT_SD, 2'h3, `LINE_SD_EVEN, 3'h1};
    rows[2] = {`FMT_SD, 2'h2, 11'h015, 3'h0};
    rows[3] = {`FMT_SD, 2'h0, `LINE_SD_ODD, 3'h0};
    rows[4] = {`FMT_525P, 2'h0, 11'h029, 3'h2};
    rows[5] = {`FMT_525P, 2'h0, 11'h028, 3'h4};
    rows[6] = {`FMT_625P, 2'h0, 11'h02b, 3'h3};
    rows[7] = {`FMT_720P, 2'h0, 11'h018, 3'h2};
    rows[8] = {`FMT_720P, 2'h0, 11'h017, 3'h4};
    rows[9] = {`FMT_1080I, 2'h0, 11'h013, 3'h2};
    rows[10] = {`FMT_1080I, 2'h0, 11'h246, 3'h2};
    rows[11] = {`FMT_1080I, 2'h0, 11'h012, 3'h4};
    rows[12] = {`FMT_1080I, 2'h0, 11'h245, 3'h4};
    rows[13] = {`FMT_525P, 2'h0, 11'h02b, 3'h0};
    repeat (5) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    for (i = 0; i < 10; i++)
    begin
      rd(ADRS[8 * i +: 8]);
      check(regRdData, 8'h00);
    end
    typeB[5:0] = 6'h2a;
    wr(8'h5e, 8'ha9);
    for (i = 0; i < 16; i++)
    begin
      typeB[6 + 8 * i +: 8] = 8'h13 * i + 8'h07;
      wr(8'h5f + i, 8'h13 * i + 8'h07);
    end
    wr(8'h32, 8'h40);
    wr(8'h41, 8'h0a);
    wr(8'h42, 8'h5c);
    wr(8'h43, 8'h3e);
    wr(8'h99, 8'h6b);
    wr(8'h9a, 8'h12);
    wr(8'h9b, 8'h34);
    wr(8'h44, 8'h77);
    rd(8'h44);
    check(regRdData, 8'h00);
    rd(8'h6e);
    check(regRdData, typeB[133:126]);
    for (i = 0; i < 14; i++)
    begin
      runLine(rows[i]);
      ev = expOf(rows[i][2:0]);
      check({capCnt, capBits}, ev);
      check(capBits[5:0], ev[5:0]);
      check(refSeen, rows[i][2:0] == 3'h1);
    end
    wr(8'h99, 8'h2b);
    runLine(rows[1]);
    check(capCnt, 8'h00);
    runLine(rows[0]);
    check(capCnt, 8'h15);
    wr(8'h99, 8'h7b);
    runLine(rows[0]);
    ev = {8'h15, 115'h0, crc6(14'h1234, 8'h0e), 14'h1234, 1'h1};
    check({capCnt, capBits}, ev);
    wr(8'h32, 8'hc0);
    runLine(rows[4]);
    ev = {8'h14, 116'h0, crc6(14'h1c3e, 8'h0e), 14'h1c3e};
    check({capCnt, capBits}, ev);
    wr(8'h5e, 8'hab);
    runLine(rows[5]);
    ev = {8'h86, 2'h0, crc6(typeB[127:0], 8'h80), typeB[127:0]};
    check({capCnt, capBits}, ev);
    wr(8'h32, 8'h40);
    startLine(rows[4]);
    check(insertBusy, 1'b1);
    wr(8'h43, 8'hff);
    waitDone;
    check(insertBusy, 1'b0);
    check({capCnt, capBits}, expOf(3'h2));
    runLine(rows[4]);
    check(capBits, 20'ha5cff);
    // clock enable low: no write lands and read data stays put
    clkEn = 1'b0;
    wr(8'h41, 8'h55);
    rd(8'h32);
    check(regRdData, 8'hff);
    clkEn = 1'b1;
    rd(8'h41);
    check(regRdData, 8'h0a);
    // reset in mid-packet clears registers and drops the output
    startLine(rows[4]);
    repeat (12) @(posedge clk_sys);
    #1;
    check(packetBitValid, 1'b1);
    sys_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check({insertBusy, packetBitValid, refPulse}, 3'h0);
    rd(8'h32);
    check(regRdData, `RST_REG);
    conclude;
  end
endmodule // tb
